// File: core/trace_port_unit.sv
// trace port unit: register slave, width selection and formatter control
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - bit m of the width register marks port width m+1 as current
// - cold reset selects the smallest supported port width
// - type register reports major type in bits 3:0, misc or sink
// - subtype trace port only with sink major; other only with misc
// - trigger marking bit plus trigger input marks a trigger on the port
// - writing one to manual flush starts a flush; hardware clears it
// - bypass mode passes one source unformatted, others dropped
// - continuous mode frames data with trigger marks and null cycles
// - reserved mode codes refused; mode resets to zero, zero without formatter
// - status bit 3 reads one when formatter cannot stop or is absent
// - status bit 2 shows control pin, zero without parallel port
// - halted sets after stop, drain and post-amble; later data ignored
// - halted reads zero without formatter or when it cannot stop
// - only privileged word accesses; unprivileged ones get an error response
// - flush status rises at flush start, falls once prior data is out
module trace_port_unit #(
	parameter logic [31:0] SUPPORTED_WIDTHS = 32'h0000000f,
	parameter bit FORMATTER_PRESENT = 1'b1,
	parameter bit FORMATTER_STOPPABLE = 1'b1,
	parameter bit PARALLEL_PRESENT = 1'b1,
	parameter bit CTL_PIN_PRESENT = 1'b0,
	parameter bit TRIG_MARK_ALWAYS = 1'b0,
	parameter logic [3:0] MAJOR_TYPE = trace_port_pkg::MAJOR_SINK,
	parameter logic [3:0] SUB_TYPE = trace_port_pkg::SUB_PORT
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // sync reset, high
	input wire logic [31:0] s_axi_awaddr, // write address
	input wire logic [2:0] s_axi_awprot, // write protection
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic [2:0] s_axi_arprot, // read protection
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	input wire logic trace_valid_i, // source byte valid
	input wire logic [6:0] trace_src_i, // source id
	input wire logic [7:0] trace_data_i, // source byte
	input wire logic external_trigger_signal_i, // trigger input
	input wire logic stop_request_i, // formatter stop request
	output logic [31:0] port_width_o, // current width one-hot
	output logic [15:0] trace_word_o, // port word
	output logic trace_word_valid_o, // port word valid
	output logic trace_trig_o // trigger mark
);
	// ***************************************************************
	// configuration checks
	// ***************************************************************
	generate
		if (SUPPORTED_WIDTHS == 32'h0) begin : g_bad_widths
			$error("no supported port width");
		end
		if ((SUB_TYPE == trace_port_pkg::SUB_PORT && MAJOR_TYPE != trace_port_pkg::MAJOR_SINK) ||
			(SUB_TYPE == trace_port_pkg::SUB_OTHER && MAJOR_TYPE != trace_port_pkg::MAJOR_MISC)) begin : g_bad_type
			$error("subtype does not match major type");
		end
	endgenerate

	function automatic logic [31:0] lowest_bit(input logic [31:0] x);
		return x & (~x + 32'h1);
	endfunction : lowest_bit

	function automatic logic legal_mode(input logic [1:0] m);
		return m == trace_port_pkg::MODE_BYPASS || m == trace_port_pkg::MODE_CONT;
	endfunction : legal_mode

	localparam logic [31:0] PW_RESET = lowest_bit(SUPPORTED_WIDTHS);
	localparam bit UNSTOPPABLE = !FORMATTER_PRESENT || !FORMATTER_STOPPABLE;

	fmt_if f ();
	trace_formatter_engine #(
		.STOPPABLE(FORMATTER_PRESENT && FORMATTER_STOPPABLE)
	) u_engine (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.f(f.engine)
	);

	logic [1:0] formatter_mode;
	logic trig_mark_bit;
	logic manual_flush_request;
	logic flush_in_progress;
	logic flush_start;
	logic aw_held;
	logic w_held;
	logic [31:0] aw_addr;
	logic aw_priv;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;

	assign f.mode = formatter_mode;
	assign f.trig_mark_en = trig_mark_bit || TRIG_MARK_ALWAYS;
	assign f.flush_start = flush_start;
	assign f.stop_req = stop_request_i;
	assign f.ext_trig = external_trigger_signal_i;
	assign f.src_valid = trace_valid_i;
	assign f.src_id = trace_src_i;
	assign f.src_data = trace_data_i;
	assign trace_word_o = f.word;
	assign trace_word_valid_o = f.word_valid;
	assign trace_trig_o = f.word_trig;

	// ***************************************************************
	// write channel
	// ***************************************************************
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			aw_addr <= 32'h0;
			aw_priv <= 1'b0;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
			aw_priv <= s_axi_awprot[0];
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_held <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			w_held <= 1'b0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_held <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= trace_port_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (!aw_priv) begin
				s_axi_bresp <= trace_port_pkg::RESP_SLVERR;
			end else if (aw_addr == trace_port_pkg::ADDR_PORT_WIDTH || aw_addr == trace_port_pkg::ADDR_FLUSH_CONTROL ||
				aw_addr == trace_port_pkg::ADDR_FLUSH_STATUS || aw_addr == trace_port_pkg::ADDR_COMP_TYPE) begin
				s_axi_bresp <= trace_port_pkg::RESP_OKAY;
			end else begin
				s_axi_bresp <= trace_port_pkg::RESP_DECERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// only privileged full-word writes change state
	logic wr_ok;
	assign wr_ok = do_write && aw_priv && w_strb == 4'hf;

	// ***************************************************************
	// registers
	// ***************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_width_o <= PW_RESET;
		end else if (wr_ok && aw_addr == trace_port_pkg::ADDR_PORT_WIDTH) begin
			// one-hot is the writer's duty; value is kept as written
			port_width_o <= w_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			formatter_mode <= trace_port_pkg::MODE_RESET;
			trig_mark_bit <= 1'b0;
		end else if (wr_ok && aw_addr == trace_port_pkg::ADDR_FLUSH_CONTROL) begin
			if (FORMATTER_PRESENT && legal_mode(w_data[1:0])) begin
				formatter_mode <= w_data[1:0];
			end
			trig_mark_bit <= w_data[trace_port_pkg::BIT_TRIG_MARK];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flush_start <= 1'b0;
		end else begin
			flush_start <= wr_ok && aw_addr == trace_port_pkg::ADDR_FLUSH_CONTROL &&
				w_data[trace_port_pkg::BIT_MAN_FLUSH] && !manual_flush_request;
		end
	end

	// a new flush beats a completion landing in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			manual_flush_request <= 1'b0;
			flush_in_progress <= 1'b0;
		end else if (flush_start) begin
			manual_flush_request <= 1'b1;
			flush_in_progress <= 1'b1;
		end else if (f.flush_done) begin
			manual_flush_request <= 1'b0;
			flush_in_progress <= 1'b0;
		end
	end

	// ***************************************************************
	// read channel
	// ***************************************************************
	logic rd_is_type;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= trace_port_pkg::RESP_OKAY;
			rd_is_type <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= trace_port_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h0;
			rd_is_type <= s_axi_araddr == trace_port_pkg::ADDR_COMP_TYPE;
			if (!s_axi_arprot[0]) begin
				s_axi_rresp <= trace_port_pkg::RESP_SLVERR;
			end else begin
				unique case (s_axi_araddr)
					trace_port_pkg::ADDR_PORT_WIDTH: s_axi_rdata <= port_width_o;
					trace_port_pkg::ADDR_FLUSH_CONTROL: begin
						s_axi_rdata[1:0] <= formatter_mode;
						s_axi_rdata[trace_port_pkg::BIT_MAN_FLUSH] <= manual_flush_request;
						s_axi_rdata[trace_port_pkg::BIT_TRIG_MARK] <= trig_mark_bit || TRIG_MARK_ALWAYS;
					end
					trace_port_pkg::ADDR_FLUSH_STATUS: begin
						s_axi_rdata[trace_port_pkg::BIT_UNSTOPPABLE] <= UNSTOPPABLE;
						s_axi_rdata[trace_port_pkg::BIT_CTL_PIN] <= PARALLEL_PRESENT && CTL_PIN_PRESENT;
						s_axi_rdata[trace_port_pkg::BIT_HALTED] <= f.halted && !UNSTOPPABLE;
						s_axi_rdata[trace_port_pkg::BIT_FLUSHING] <= flush_in_progress;
					end
					trace_port_pkg::ADDR_COMP_TYPE: s_axi_rdata[7:0] <= {SUB_TYPE, MAJOR_TYPE};
					default: s_axi_rresp <= trace_port_pkg::RESP_DECERR;
				endcase
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ***************************************************************
	// assertions
	// ***************************************************************
	AST_WIDTH_RESET: assert property (@(posedge clk_i) $fell(rst_i) |-> port_width_o == PW_RESET)
		else $error("port width not at smallest supported after reset");
	AST_WIDTH_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ok && aw_addr == trace_port_pkg::ADDR_PORT_WIDTH |=> port_width_o == $past(w_data))
		else $error("port width write not taken");
	AST_TYPE_PAIR: assert property (@(posedge clk_i) disable iff (rst_i)
		s_axi_rvalid && rd_is_type && s_axi_rresp == trace_port_pkg::RESP_OKAY |->
		s_axi_rdata[3:0] == MAJOR_TYPE && (s_axi_rdata[7:4] != trace_port_pkg::SUB_PORT ||
		s_axi_rdata[3:0] == trace_port_pkg::MAJOR_SINK))
		else $error("component type read wrong");
	AST_TRIG_MARK: assert property (@(posedge clk_i) disable iff (rst_i)
		external_trigger_signal_i && (trig_mark_bit || TRIG_MARK_ALWAYS) |=> trace_trig_o)
		else $error("trigger not marked");
	AST_TRIG_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
		!external_trigger_signal_i |=> !trace_trig_o)
		else $error("trigger marked without trigger input");
	AST_FLUSH_RISE: assert property (@(posedge clk_i) disable iff (rst_i)
		flush_start |=> flush_in_progress && manual_flush_request ##1 flush_in_progress[*2])
		else $error("flush status not raised and held");
	AST_FLUSH_BOUNDED: assert property (@(posedge clk_i) disable iff (rst_i)
		flush_in_progress[*3] |=> !flush_in_progress)
		else $error("flush status stuck high");
	AST_FLUSH_SELF_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(manual_flush_request) |-> $fell(flush_in_progress))
		else $error("flush bit and flush status out of step");
	AST_FLUSH_ENDS: assert property (@(posedge clk_i) disable iff (rst_i)
		flush_start ##1 !flush_start[*4] |-> !manual_flush_request)
		else $error("manual flush never cleared");
	AST_MODE_LEGAL: assert property (@(posedge clk_i) disable iff (rst_i)
		legal_mode(formatter_mode) && (FORMATTER_PRESENT || formatter_mode == 2'h0))
		else $error("mode holds a reserved code");
	AST_BYPASS_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
		f.halted == 1'b0 && formatter_mode == trace_port_pkg::MODE_BYPASS && trace_valid_i &&
		trace_src_i != trace_port_pkg::INSTR_SRC_ID |=> !trace_word_valid_o)
		else $error("bypass passed a foreign source");
	AST_UNPRIV_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		do_write && !aw_priv |=> s_axi_bvalid && s_axi_bresp == trace_port_pkg::RESP_SLVERR)
		else $error("unprivileged write not refused");
	AST_UNPRIV_READ: assert property (@(posedge clk_i) disable iff (rst_i)
		s_axi_arvalid && s_axi_arready && !s_axi_arprot[0] |=>
		s_axi_rvalid && s_axi_rresp == trace_port_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unprivileged read not refused");
	// narrow writes are answered but must leave the width and mode registers alone
	AST_NARROW_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		do_write && w_strb != 4'hf |=> $stable(port_width_o) && $stable(formatter_mode))
		else $error("narrow write changed a register");
	AST_STATUS_CAPS: assert property (@(posedge clk_i) disable iff (rst_i)
		s_axi_arvalid && s_axi_arready && s_axi_arprot[0] &&
		s_axi_araddr == trace_port_pkg::ADDR_FLUSH_STATUS |=>
		s_axi_rdata[trace_port_pkg::BIT_UNSTOPPABLE] == (!FORMATTER_PRESENT || !FORMATTER_STOPPABLE) &&
		s_axi_rdata[trace_port_pkg::BIT_CTL_PIN] == (PARALLEL_PRESENT && CTL_PIN_PRESENT))
		else $error("status capability bits wrong");
	AST_HALT_ONLY_STOPPABLE: assert property (@(posedge clk_i) disable iff (rst_i)
		f.halted |-> !UNSTOPPABLE && $past(stop_request_i))
		else $error("halted without a stoppable formatter and a stop request");
	AST_POSTAMBLE_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(f.halted) && formatter_mode == trace_port_pkg::MODE_CONT |->
		$past(trace_word_valid_o) && $past(trace_word_o) == trace_port_pkg::POSTAMBLE_WORD)
		else $error("halted before the post-amble went out");
	AST_HALT_IGNORES: assert property (@(posedge clk_i) disable iff (rst_i)
		f.halted |-> !trace_word_valid_o)
		else $error("data passed while halted");

	COV_FLUSH_DONE: cover property (@(posedge clk_i) disable iff (rst_i) $fell(flush_in_progress));
	COV_HALTED: cover property (@(posedge clk_i) disable iff (rst_i) $rose(f.halted));
	COV_TRIGGER: cover property (@(posedge clk_i) disable iff (rst_i) trace_trig_o && trace_word_valid_o);
	COV_BYPASS_WORD: cover property (@(posedge clk_i) disable iff (rst_i)
		formatter_mode == trace_port_pkg::MODE_BYPASS && trace_word_valid_o);
	COV_POSTAMBLE: cover property (@(posedge clk_i) disable iff (rst_i)
		trace_word_valid_o && trace_word_o == trace_port_pkg::POSTAMBLE_WORD);
endmodule : trace_port_unit
`default_nettype wire

// File: core/trace_port_pkg.sv
// shared constants of the trace port control unit
package trace_port_pkg;
	// ***************************************************************
	// register byte addresses
	// ***************************************************************
	localparam logic [31:0] ADDR_PORT_WIDTH = 32'he0040004;
	localparam logic [31:0] ADDR_FLUSH_STATUS = 32'he0040300;
	localparam logic [31:0] ADDR_FLUSH_CONTROL = 32'he0040304;
	localparam logic [31:0] ADDR_COMP_TYPE = 32'he0040fcc;
	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int BIT_TRIG_MARK = 8;
	localparam int BIT_MAN_FLUSH = 6;
	localparam int BIT_UNSTOPPABLE = 3;
	localparam int BIT_CTL_PIN = 2;
	localparam int BIT_HALTED = 1;
	localparam int BIT_FLUSHING = 0;
	// ***************************************************************
	// codes and reset values
	// ***************************************************************
	localparam logic [1:0] MODE_BYPASS = 2'h0;
	localparam logic [1:0] MODE_CONT = 2'h2;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [3:0] MAJOR_MISC = 4'h0;
	localparam logic [3:0] MAJOR_SINK = 4'h1;
	localparam logic [3:0] SUB_OTHER = 4'h0;
	localparam logic [3:0] SUB_PORT = 4'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam logic [15:0] NULL_WORD = 16'h0000;
	localparam logic [15:0] POSTAMBLE_WORD = 16'h7f00;
	localparam logic [6:0] INSTR_SRC_ID = 7'h01;
	// ***************************************************************
	// timing
	// ***************************************************************
	localparam logic [2:0] DRAIN_CYCLES = 3'h2;
endpackage : trace_port_pkg

// File: core/fmt_if.sv
// control and stream signals between the register side and the formatter engine
`timescale 1ns/1ps
`default_nettype none
interface fmt_if;
	logic [1:0] mode;
	logic trig_mark_en;
	logic flush_start;
	logic flush_done;
	logic stop_req;
	logic halted;
	logic ext_trig;
	logic src_valid;
	logic [6:0] src_id;
	logic [7:0] src_data;
	logic [15:0] word;
	logic word_valid;
	logic word_trig;
	modport ctrl (output mode, trig_mark_en, flush_start, stop_req, ext_trig, src_valid, src_id, src_data,
		input flush_done, halted, word, word_valid, word_trig);
	modport engine (input mode, trig_mark_en, flush_start, stop_req, ext_trig, src_valid, src_id, src_data,
		output flush_done, halted, word, word_valid, word_trig);
endinterface : fmt_if
`default_nettype wire

// File: core/trace_formatter_engine.sv
// formatter engine: bypass or continuous framing, flush drain, stop and post-amble
`timescale 1ns/1ps
`default_nettype none
module trace_formatter_engine #(
	parameter bit STOPPABLE = 1'b1
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // sync reset
	fmt_if.engine f // control and stream
);
	typedef enum logic [1:0] {RUN, DRAIN, POST, HALT} phase_e;
	phase_e phase;
	logic [2:0] flush_cnt;
	logic [2:0] stop_cnt;

	// ***************************************************************
	// output word
	// ***************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			f.word <= trace_port_pkg::NULL_WORD;
			f.word_valid <= 1'b0;
		end else if (phase == POST) begin
			// a raw stream carries no framing, so no post-amble either
			f.word <= trace_port_pkg::POSTAMBLE_WORD;
			f.word_valid <= f.mode == trace_port_pkg::MODE_CONT;
		end else if (phase == HALT) begin
			// data after the stop is dropped
			f.word_valid <= 1'b0;
		end else if (f.mode == trace_port_pkg::MODE_CONT) begin
			f.word <= f.src_valid ? {1'b0, f.src_id, f.src_data} : trace_port_pkg::NULL_WORD;
			f.word_valid <= 1'b1;
		end else begin
			f.word <= {8'h00, f.src_data};
			f.word_valid <= f.src_valid && (f.src_id == trace_port_pkg::INSTR_SRC_ID);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			f.word_trig <= 1'b0;
		end else begin
			f.word_trig <= f.ext_trig && f.trig_mark_en;
		end
	end

	// ***************************************************************
	// flush drain
	// ***************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flush_cnt <= 3'h0;
			f.flush_done <= 1'b0;
		end else begin
			f.flush_done <= (flush_cnt == 3'h1) && !f.flush_start;
			if (f.flush_start) begin
				flush_cnt <= trace_port_pkg::DRAIN_CYCLES;
			end else if (flush_cnt != 3'h0) begin
				flush_cnt <= flush_cnt - 3'h1;
			end
		end
	end

	// ***************************************************************
	// stop sequence
	// ***************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase <= RUN;
			stop_cnt <= 3'h0;
			f.halted <= 1'b0;
		end else begin
			unique case (phase)
				RUN: begin
					// either mode may stop, so the mode can be changed while halted
					if (STOPPABLE && f.stop_req) begin
						phase <= DRAIN;
						stop_cnt <= trace_port_pkg::DRAIN_CYCLES;
					end
				end
				DRAIN: begin
					stop_cnt <= stop_cnt - 3'h1;
					if (stop_cnt == 3'h1) begin
						phase <= POST;
					end
				end
				POST: begin
					phase <= HALT;
				end
				HALT: begin
					// in continuous mode the flag rises only once the post-amble word has left the port
					f.halted <= f.stop_req;
					if (!f.stop_req) begin
						phase <= RUN;
					end
				end
			endcase
		end
	end
endmodule : trace_formatter_engine
`default_nettype wire

// File: verif/trace_partner_model.sv
// trace sources and capture probe on the far side of the trace port
`timescale 1ns/1ps
`default_nettype none
module trace_partner_model (
	input wire logic clk_i, // clock
	input wire logic en_i, // sources on
	input wire logic solo_i, // instrumentation source only
	input wire logic bypass_i, // probe expects raw bytes
	output logic valid_o, // source byte valid
	output logic [6:0] src_o, // source id
	output logic [7:0] data_o, // source byte
	input wire logic [15:0] word_i, // port word
	input wire logic word_valid_i, // port word valid
	output int words_o, // words captured
	output int bad_o // malformed words
);
	logic [7:0] cnt = 8'h00;
	initial begin
		valid_o = 1'b0;
		src_o = 7'h00;
		data_o = 8'h00;
		words_o = 0;
		bad_o = 0;
	end
	// idle lines wander so a stale byte never looks like data
	always @(posedge clk_i) begin
		cnt <= cnt + 8'h01;
		valid_o <= en_i;
		src_o <= !en_i ? ~src_o : (solo_i || cnt[0]) ? trace_port_pkg::INSTR_SRC_ID : 7'h02;
		data_o <= en_i ? cnt : ~data_o;
	end
	always @(posedge clk_i) begin
		if (word_valid_i) begin
			words_o <= words_o + 1;
			if (bypass_i ? word_i[15:8] !== 8'h00 : word_i[15] !== 1'b0) bad_o <= bad_o + 1;
		end
	end
endmodule : trace_partner_model
`default_nettype wire

// File: verif/testbench.sv
// register and stream tests of the trace port unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [31:0] a_w = trace_port_pkg::ADDR_PORT_WIDTH;
	localparam logic [31:0] a_st = trace_port_pkg::ADDR_FLUSH_STATUS;
	localparam logic [31:0] a_ctl = trace_port_pkg::ADDR_FLUSH_CONTROL;
	localparam logic [1:0] ok = trace_port_pkg::RESP_OKAY;
	localparam logic [1:0] slverr = trace_port_pkg::RESP_SLVERR;
	logic clk_i = 1'b0, rst_i = 1'b1;
	logic [31:0] awaddr, wdata, araddr, rdata, port_width_o, d;
	logic [2:0] awprot, arprot;
	logic [3:0] wstrb = 4'hf;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	logic tv, trig, stop, en, solo, byp, trace_word_valid_o, trace_trig_o;
	logic [6:0] tsrc;
	logic [7:0] tdata;
	logic [15:0] trace_word_o;
	int num_errors = 0, samples_checked = 0, p_words, p_bad;
	trace_port_unit DUT (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .trace_valid_i(tv), .trace_src_i(tsrc), .trace_data_i(tdata),
		.external_trigger_signal_i(trig), .stop_request_i(stop), .port_width_o(port_width_o),
		.trace_word_o(trace_word_o), .trace_word_valid_o(trace_word_valid_o), .trace_trig_o(trace_trig_o));
	trace_partner_model partner (.clk_i(clk_i), .en_i(en), .solo_i(solo), .bypass_i(byp), .valid_o(tv),
		.src_o(tsrc), .data_o(tdata), .word_i(trace_word_o), .word_valid_i(trace_word_valid_o),
		.words_o(p_words), .bad_o(p_bad));
	initial forever #2.5 clk_i = ~clk_i;
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		cmp({30'h0, got}, {30'h0, exp});
	endtask : cmp_resp
	task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [2:0] p, input logic [1:0] er);
		@(posedge clk_i);
		awaddr <= a;
		wdata <= v;
		awprot <= p;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		cmp_resp(bresp, er);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [2:0] p, input logic [1:0] er);
		@(posedge clk_i);
		araddr <= a;
		arprot <= p;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		cmp_resp(rresp, er);
		rready <= 1'b0;
	endtask : rd
	task automatic chk(input logic [31:0] a, input logic [31:0] exp);
		rd(a, 3'h1, ok);
		cmp(d, exp);
	endtask : chk
	// bounded poll of one status bit
	task automatic poll(input int b, input logic v);
		for (int i = 0; i < 20; i++) begin
			rd(a_st, 3'h1, ok);
			if (d[b] === v) break;
		end
		cmp({31'h0, d[b]}, {31'h0, v});
	endtask : poll
	task end_sim;
		if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_sim
	initial begin
		{awaddr, wdata, araddr, awprot, arprot} = '0;
		{awvalid, wvalid, bready, arvalid, rready, trig, stop, en, solo, byp} = '0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(a_w, 32'h1);
		cmp(port_width_o, 32'h1);
		chk(a_ctl, 32'h0);
		chk(a_st, 32'h0);
		chk(trace_port_pkg::ADDR_COMP_TYPE, 32'h11);
		wr(a_w, 32'h8, 3'h1, ok);
		chk(a_w, 32'h8);
		cmp(port_width_o, 32'h8);
		wr(a_w, 32'h2, 3'h0, slverr);
		rd(a_w, 3'h0, slverr);
		cmp(d, 32'h0);
		wstrb <= 4'h3;
		wr(a_w, 32'h4, 3'h1, ok);
		wstrb <= 4'hf;
		chk(a_w, 32'h8);
		rd(32'he0040100, 3'h1, trace_port_pkg::RESP_DECERR);
		solo <= 1'b1;
		byp <= 1'b1;
		en <= 1'b1;
		wr(a_ctl, 32'h3, 3'h1, ok);
		chk(a_ctl, 32'h0);
		cmp(32'(p_words > 0), 32'h1);
		cmp(p_bad, 32'h0);
		en <= 1'b0;
		// the mode register takes a legal code at any time; here it is changed while halted
		stop <= 1'b1;
		poll(1, 1'b1);
		wr(a_ctl, 32'h102, 3'h1, ok);
		stop <= 1'b0;
		byp <= 1'b0;
		chk(a_ctl, 32'h102);
		solo <= 1'b0;
		en <= 1'b1;
		repeat (8) @(posedge clk_i);
		en <= 1'b0;
		repeat (4) @(posedge clk_i);
		#1 cmp(p_bad, 32'h0);
		cmp({31'h0, trace_word_valid_o}, 32'h1);
		cmp({16'h0, trace_word_o}, {16'h0, trace_port_pkg::NULL_WORD});
		@(posedge clk_i);
		trig <= 1'b1;
		@(posedge clk_i);
		trig <= 1'b0;
		#1 cmp({31'h0, trace_trig_o}, 32'h1);
		@(posedge clk_i);
		#1 cmp({31'h0, trace_trig_o}, 32'h0);
		wr(a_ctl, 32'h142, 3'h1, ok);
		poll(0, 1'b1);
		poll(0, 1'b0);
		chk(a_ctl, 32'h102);
		stop <= 1'b1;
		en <= 1'b1;
		poll(1, 1'b1);
		@(posedge clk_i);
		#1 cmp({31'h0, trace_word_valid_o}, 32'h0);
		en <= 1'b0;
		wr(a_ctl, 32'h100, 3'h1, ok);
		chk(a_ctl, 32'h100);
		stop <= 1'b0;
		end_sim;
	end
	initial begin
		#(20000 * 5);
		num_errors++;
		end_sim;
	end
endmodule : testbench
`default_nettype wire
